// [akb_pkg.sv]
`default_nettype none
package akb_pkg;
  localparam int KEY_W = 185;
  localparam int NUM_RNG = 8;
  localparam logic [3:0] TYPE_ARP = 4'h3;
  localparam logic [3:0] TYPE_IP4_L4 = 4'h4;
  // common positions
  localparam int P_TYPE = 0;
  localparam int P_FIRST = 4;
  // resolution key positions
  localparam int PA_SMAC = 46;
  localparam int PA_HW_ETH = 94;
  localparam int PA_PROTO_IP = 95;
  localparam int PA_LEN_OK = 96;
  localparam int PA_TGT_EQ = 97;
  localparam int PA_SND_EQ = 98;
  localparam int PA_OP_UNK = 99;
  localparam int PA_OP = 100;
  localparam int PA_DIP = 102;
  localparam int PA_SIP = 134;
  localparam int PA_IP_EQ = 166;
  // ip transport key positions
  localparam int PI_V4 = 46;
  localparam int PI_FRAG = 47;
  localparam int PI_LATER = 48;
  localparam int PI_OPTS = 49;
  localparam int PI_TTL = 50;
  localparam int PI_TOS = 51;
  localparam int PI_DIP = 59;
  localparam int PI_SIP = 91;
  localparam int PI_IP_EQ = 123;
  localparam int PI_TCP = 124;
  localparam int PI_DPORT = 125;
  localparam int PI_SPORT = 141;
  localparam int PI_RNG = 157;
  localparam int PI_PORT_EQ = 165;
  localparam int PI_FLAGS = 166;
  localparam int PI_DOM = 173;
  localparam int PI_VER = 181;
  localparam int PI_L4_LO = 125;
  // frame header values
  localparam logic [15:0] HTYPE_ETH = 16'h0001;
  localparam logic [15:0] PTYPE_IP = 16'h0800;
  localparam logic [7:0] HLEN_ETH = 8'h06;
  localparam logic [7:0] PLEN_IP = 8'h04;
  localparam logic [15:0] OP_ARP_REQ = 16'h0001;
  localparam logic [15:0] OP_ARP_REP = 16'h0002;
  localparam logic [15:0] OP_RARP_REQ = 16'h0003;
  localparam logic [15:0] OP_RARP_REP = 16'h0004;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [3:0] IHL_PLAIN = 4'h5;
  // register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_RTYPE = 12'h008;
  localparam logic [11:0] ADDR_RBASE = 12'h010;
  localparam logic [11:0] ADDR_RLAST = 12'h02c;
  localparam int CTRL_V6STD = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [23:0] RTYPE_RST = 24'h00_0000;
  localparam logic [31:0] RBOUND_RST = 32'hffff_0000;
  typedef enum logic [2:0] {
    RNG_SPORT = 3'b000,
    RNG_DPORT = 3'b001,
    RNG_EITHER = 3'b010,
    RNG_VID = 3'b011,
    RNG_DSCP = 3'b100
  } akb_rng_kind_t;
endpackage
`default_nettype wire

// [akb_range_check.sv]
`default_nettype none
module akb_range_check (
  input wire logic [15:0] sport,
  input wire logic [15:0] dport,
  input wire logic [11:0] vid,
  input wire logic [5:0] dscp,
  input wire logic [23:0] kinds,
  input wire logic [7:0][15:0] lo,
  input wire logic [7:0][15:0] hi,
  output logic [7:0] hit
);
  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] l,
                                  input logic [15:0] h);
    in_rng = (v >= l) && (v <= h);
  endfunction

  always_comb begin
    for (int i = 0; i < akb_pkg::NUM_RNG; i++) begin
      case (akb_pkg::akb_rng_kind_t'(kinds[i*3 +: 3]))
        akb_pkg::RNG_SPORT: hit[i] = in_rng(sport, lo[i], hi[i]);
        akb_pkg::RNG_DPORT: hit[i] = in_rng(dport, lo[i], hi[i]);
        akb_pkg::RNG_EITHER: hit[i] = in_rng(sport, lo[i], hi[i]) |
                                      in_rng(dport, lo[i], hi[i]);
        akb_pkg::RNG_VID: hit[i] = in_rng({4'h0, vid}, lo[i], hi[i]);
        akb_pkg::RNG_DSCP: hit[i] = in_rng({10'h000, dscp}, lo[i], hi[i]);
        default: hit[i] = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// [akb_l4_flag_sel.sv]
`default_nettype none
module akb_l4_flag_sel (
  input wire logic is_ptp,
  input wire logic [31:0] tcp_seq,
  input wire logic [5:0] tcp_flags,
  input wire logic [3:0] ptp_msg_type,
  input wire logic [7:0] ptp_flag_field,
  output logic [6:0] flags
);
  // order: seq/type0, fin, syn, rst, psh, ack, urg
  always_comb begin
    if (is_ptp) begin
      flags = {ptp_flag_field[7], ptp_flag_field[2], ptp_flag_field[1],
               ptp_msg_type};
    end else begin
      flags = {tcp_flags, tcp_seq == 32'h0000_0000};
    end
  end
endmodule
`default_nettype wire

// [akb_key_builder.sv]
// Summary of operation
// - resolution key carries frame source MAC from bit 46
// - bit 94 set when hardware space is Ethernet
// - bit 95 set when protocol space is IP
// - bit 96 set when address lengths are 6 and 4
// - bit 97 set when target hardware address equals source MAC
// - bit 98 set when sender hardware address equals source MAC
// - two-bit operation at 100; bit 99 flags unknown opcode
// - target address at 102, sender at 134, bit 166 when equal
// - bit 46 marks v4; v6 uses this key when its own key disabled
// - bit 47 set when more-fragments or offset nonzero
// - bit 48 for later fragments; their transport fields are don't-care
// - bit 49 when header length above 5; transport fields don't-care
// - bit 50 when TTL nonzero; service byte from bit 51
// - addresses at 59 and 91; v6 puts source halves there
// - bit 123 when full source and destination addresses equal
// - bit 124 set for IS_TCP_FLAG, clear for UDP
// - ports at 125 and 141; bit 165 when equal
// - eight range hits at bit 157
// - bit 166 sequence zero for IS_TCP_FLAG, message type bit 0 for PTP
// - bits 167-169 IS_TCP_FLAG FIN SYN RST, or PTP message type bits 1-3
// - bits 170-172 IS_TCP_FLAG PSH ACK URG, or PTP flag bits 1, 2, 7
// - PTP domain at 173 and version at 181
// - four-bit key type at bit 0: 3 resolution, 4 transport
// - bit 4 set on first lookup, clear on second
//
// The implementer's own choices: register access over APB and the address map.
`default_nettype none
module akb_key_builder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic frm_first_lookup,
  input wire logic frm_is_arp,
  input wire logic frm_is_ip4,
  input wire logic frm_is_ip6,
  input wire logic frm_is_ptp,
  input wire logic [47:0] src_mac_field,
  input wire logic [15:0] arp_hw_space,
  input wire logic [15:0] arp_proto_space,
  input wire logic [7:0] arp_hw_len,
  input wire logic [7:0] arp_proto_len,
  input wire logic [15:0] arp_op,
  input wire logic [47:0] arp_sender_hw,
  input wire logic [47:0] arp_target_hw,
  input wire logic [31:0] arp_sender_ip,
  input wire logic [31:0] arp_target_ip,
  input wire logic ip_more_frags,
  input wire logic [12:0] ip_frag_offset,
  input wire logic [3:0] ip_hdr_len,
  input wire logic [7:0] ip_ttl,
  input wire logic [7:0] service_type_field,
  input wire logic [7:0] ip_proto,
  input wire logic [127:0] ip_src,
  input wire logic [127:0] ip_dst,
  input wire logic [15:0] src_port_field,
  input wire logic [15:0] dest_port_field,
  input wire logic [31:0] tcp_seq,
  input wire logic [5:0] tcp_flags,
  input wire logic [3:0] ptp_msg_type,
  input wire logic [7:0] ptp_flag_field,
  input wire logic [7:0] ptp_domain_field,
  input wire logic [3:0] ptp_version_field,
  input wire logic [11:0] cls_vid,
  input wire logic [5:0] cls_dscp,
  output logic key_valid,
  input wire logic key_ready,
  output logic [akb_pkg::KEY_W-1:0] key_data,
  output logic [akb_pkg::KEY_W-1:0] key_mask
);
  logic [31:0] ctrl;
  logic [23:0] rng_kinds;
  logic [7:0][31:0] rng_bound;
  logic [7:0][15:0] rng_lo;
  logic [7:0][15:0] rng_hi;
  logic [15:0] built_cnt;
  logic [15:0] skipped_cnt;
  logic [7:0] range_hit_mask;
  logic [6:0] l4_flags;
  logic v6_standard_key;
  logic is_tcp_flag;
  logic l4_frame;
  logic arp_sel;
  logic ip_sel;
  logic take;
  logic later_fragment_flag;
  logic has_ip_options_flag;
  logic l4_void;
  logic ptp_sel;
  logic [31:0] next_prdata;
  logic addr_ok;
  logic [akb_pkg::KEY_W-1:0] next_key_data;
  logic [akb_pkg::KEY_W-1:0] next_key_mask;

  assign v6_standard_key = ctrl[akb_pkg::CTRL_V6STD];
  assign pready = 1'b1;
  assign addr_ok = (paddr == akb_pkg::ADDR_CTRL) ||
                   (paddr == akb_pkg::ADDR_STAT) ||
                   (paddr == akb_pkg::ADDR_RTYPE) ||
                   ((paddr >= akb_pkg::ADDR_RBASE) &&
                    (paddr <= akb_pkg::ADDR_RLAST) &&
                    (paddr[1:0] == 2'b00));
  assign pslverr = psel & penable & ~addr_ok;

  // bounds sit in consecutive words counted from the range base, not at
  // the raw address bits, so the base need not be eight-word aligned
  function automatic logic [2:0] rng_index(input logic [11:0] a);
    logic [11:0] off;
    off = a - akb_pkg::ADDR_RBASE;
    return off[4:2];
  endfunction

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= akb_pkg::CTRL_RST;
    end else if (psel && penable && pwrite &&
                 paddr == akb_pkg::ADDR_CTRL) begin
      ctrl <= {31'h0000_0000, pwdata[akb_pkg::CTRL_V6STD]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rng_kinds <= akb_pkg::RTYPE_RST;
    end else if (psel && penable && pwrite &&
                 paddr == akb_pkg::ADDR_RTYPE) begin
      rng_kinds <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < akb_pkg::NUM_RNG; i++) begin
        rng_bound[i] <= akb_pkg::RBOUND_RST;
      end
    end else if (psel && penable && pwrite && addr_ok &&
                 paddr >= akb_pkg::ADDR_RBASE) begin
      rng_bound[rng_index(paddr)] <= pwdata;
    end
  end

  always_comb begin
    for (int i = 0; i < akb_pkg::NUM_RNG; i++) begin
      rng_lo[i] = rng_bound[i][15:0];
      rng_hi[i] = rng_bound[i][31:16];
    end
  end

  // read data is captured in the setup phase so it stands in access
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == akb_pkg::ADDR_CTRL) begin
      next_prdata = ctrl;
    end else if (paddr == akb_pkg::ADDR_STAT) begin
      next_prdata = {skipped_cnt, built_cnt};
    end else if (paddr == akb_pkg::ADDR_RTYPE) begin
      next_prdata = {8'h00, rng_kinds};
    end else if (addr_ok) begin
      next_prdata = rng_bound[rng_index(paddr)];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // frame classification
  assign is_tcp_flag = (ip_proto == akb_pkg::PROTO_TCP);
  assign l4_frame = is_tcp_flag || (ip_proto == akb_pkg::PROTO_UDP);
  assign arp_sel = frm_is_arp;
  // v6 frames fall back to this key only while their own is off
  assign ip_sel = l4_frame &&
                  (frm_is_ip4 || (frm_is_ip6 && !v6_standard_key));
  assign ptp_sel = frm_is_ptp && !is_tcp_flag;
  assign later_fragment_flag = (ip_frag_offset != 13'h0000);
  assign has_ip_options_flag = frm_is_ip4 &&
                               (ip_hdr_len > akb_pkg::IHL_PLAIN);
  // options are not skipped, so transport bytes cannot be trusted
  assign l4_void = later_fragment_flag || has_ip_options_flag;
  assign frm_ready = ~key_valid | key_ready;
  assign take = frm_valid & frm_ready;

  akb_range_check u_rng (
    .sport(src_port_field),
    .dport(dest_port_field),
    .vid(cls_vid),
    .dscp(cls_dscp),
    .kinds(rng_kinds),
    .lo(rng_lo),
    .hi(rng_hi),
    .hit(range_hit_mask)
  );

  akb_l4_flag_sel u_flags (
    .is_ptp(ptp_sel),
    .tcp_seq(tcp_seq),
    .tcp_flags(tcp_flags),
    .ptp_msg_type(ptp_msg_type),
    .ptp_flag_field(ptp_flag_field),
    .flags(l4_flags)
  );

  // key assembly
  // mask bit 1 means the array compares that bit; 0 is don't-care
  always_comb begin
    next_key_data = '0;
    next_key_mask = '0;
    next_key_data[akb_pkg::P_FIRST] = frm_first_lookup;
    next_key_mask[akb_pkg::P_TYPE +: 5] = 5'h1f;
    if (arp_sel) begin
      next_key_data[akb_pkg::P_TYPE +: 4] = akb_pkg::TYPE_ARP;
      next_key_data[akb_pkg::PA_SMAC +: 48] = src_mac_field;
      next_key_mask[akb_pkg::PA_SMAC +: 48] = '1;
      next_key_data[akb_pkg::PA_HW_ETH] =
        (arp_hw_space == akb_pkg::HTYPE_ETH);
      next_key_data[akb_pkg::PA_PROTO_IP] =
        (arp_proto_space == akb_pkg::PTYPE_IP);
      next_key_data[akb_pkg::PA_LEN_OK] =
        (arp_hw_len == akb_pkg::HLEN_ETH) &&
        (arp_proto_len == akb_pkg::PLEN_IP);
      next_key_data[akb_pkg::PA_TGT_EQ] =
        (arp_target_hw == src_mac_field);
      next_key_data[akb_pkg::PA_SND_EQ] =
        (arp_sender_hw == src_mac_field);
      case (arp_op)
        akb_pkg::OP_ARP_REQ: next_key_data[akb_pkg::PA_OP +: 2] = 2'h0;
        akb_pkg::OP_ARP_REP: next_key_data[akb_pkg::PA_OP +: 2] = 2'h1;
        akb_pkg::OP_RARP_REQ: next_key_data[akb_pkg::PA_OP +: 2] = 2'h2;
        akb_pkg::OP_RARP_REP: next_key_data[akb_pkg::PA_OP +: 2] = 2'h3;
        default: next_key_data[akb_pkg::PA_OP_UNK] = 1'b1;
      endcase
      next_key_mask[akb_pkg::PA_HW_ETH +: 8] = 8'hff;
      next_key_data[akb_pkg::PA_DIP +: 32] = arp_target_ip;
      next_key_data[akb_pkg::PA_SIP +: 32] = arp_sender_ip;
      next_key_mask[akb_pkg::PA_DIP +: 64] = '1;
      next_key_data[akb_pkg::PA_IP_EQ] =
        (arp_target_ip == arp_sender_ip);
      next_key_mask[akb_pkg::PA_IP_EQ] = 1'b1;
    end else if (ip_sel) begin
      next_key_data[akb_pkg::P_TYPE +: 4] = akb_pkg::TYPE_IP4_L4;
      next_key_data[akb_pkg::PI_V4] = frm_is_ip4;
      next_key_data[akb_pkg::PI_FRAG] =
        ip_more_frags || later_fragment_flag;
      next_key_data[akb_pkg::PI_LATER] = later_fragment_flag;
      next_key_data[akb_pkg::PI_OPTS] = has_ip_options_flag;
      next_key_data[akb_pkg::PI_TTL] = (ip_ttl != 8'h00);
      next_key_data[akb_pkg::PI_TOS +: 8] = service_type_field;
      if (frm_is_ip4) begin
        next_key_data[akb_pkg::PI_DIP +: 32] = ip_dst[31:0];
        next_key_data[akb_pkg::PI_SIP +: 32] = ip_src[31:0];
        next_key_data[akb_pkg::PI_IP_EQ] =
          (ip_src[31:0] == ip_dst[31:0]);
      end else begin
        next_key_data[akb_pkg::PI_DIP +: 32] = ip_src[63:32];
        next_key_data[akb_pkg::PI_SIP +: 32] = ip_src[31:0];
        next_key_data[akb_pkg::PI_IP_EQ] = (ip_src == ip_dst);
      end
      next_key_data[akb_pkg::PI_TCP] = is_tcp_flag;
      next_key_mask[akb_pkg::PI_V4 +: 79] = '1;
      next_key_data[akb_pkg::PI_DPORT +: 16] = dest_port_field;
      next_key_data[akb_pkg::PI_SPORT +: 16] = src_port_field;
      next_key_data[akb_pkg::PI_RNG +: 8] = range_hit_mask;
      next_key_data[akb_pkg::PI_PORT_EQ] =
        (src_port_field == dest_port_field);
      next_key_mask[akb_pkg::PI_DPORT +: 41] = '1;
      // plain UDP has no flag bits to compare
      if (is_tcp_flag || ptp_sel) begin
        next_key_data[akb_pkg::PI_FLAGS +: 7] = l4_flags;
        next_key_mask[akb_pkg::PI_FLAGS +: 7] = 7'h7f;
      end
      if (ptp_sel) begin
        next_key_data[akb_pkg::PI_DOM +: 8] = ptp_domain_field;
        next_key_data[akb_pkg::PI_VER +: 4] = ptp_version_field;
        next_key_mask[akb_pkg::PI_DOM +: 12] = 12'hfff;
      end
      if (l4_void) begin
        next_key_data[akb_pkg::KEY_W-1:akb_pkg::PI_L4_LO] = '0;
        next_key_mask[akb_pkg::KEY_W-1:akb_pkg::PI_L4_LO] = '0;
      end
    end
  end

  // output stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_valid <= 1'b0;
    end else if (take) begin
      key_valid <= arp_sel | ip_sel;
    end else if (key_ready) begin
      key_valid <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_data <= '0;
      key_mask <= '0;
    end else if (take && (arp_sel || ip_sel)) begin
      key_data <= next_key_data;
      key_mask <= next_key_mask;
    end
  end

  // counters saturate so software can tell overflow from wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      built_cnt <= 16'h0000;
    end else if (take && (arp_sel || ip_sel) && built_cnt != 16'hffff) begin
      built_cnt <= built_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skipped_cnt <= 16'h0000;
    end else if (take && !arp_sel && !ip_sel &&
                 skipped_cnt != 16'hffff) begin
      skipped_cnt <= skipped_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [akb_key_builder_checker.sv]
`default_nettype none
module akb_key_builder_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frm_valid,
  input wire logic frm_ready,
  input wire logic frm_first_lookup,
  input wire logic frm_is_arp,
  input wire logic frm_is_ip4,
  input wire logic [47:0] src_mac_field,
  input wire logic [7:0] arp_hw_len,
  input wire logic [7:0] arp_proto_len,
  input wire logic [15:0] arp_op,
  input wire logic [31:0] arp_sender_ip,
  input wire logic [31:0] arp_target_ip,
  input wire logic [12:0] ip_frag_offset,
  input wire logic [3:0] ip_hdr_len,
  input wire logic [7:0] ip_proto,
  input wire logic key_valid,
  input wire logic key_ready,
  input wire logic [akb_pkg::KEY_W-1:0] key_data,
  input wire logic [akb_pkg::KEY_W-1:0] key_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    frm_valid && frm_ready;
  endsequence
  sequence s_arp;
    s_take ##0 frm_is_arp;
  endsequence
  // ip frames only reach the transport key with a tcp or udp payload
  sequence s_ip;
    s_take ##0 (!frm_is_arp && frm_is_ip4 &&
      (ip_proto == akb_pkg::PROTO_TCP || ip_proto == akb_pkg::PROTO_UDP));
  endsequence
  property p_arp_type;
    s_arp |=> key_valid && key_data[3:0] == akb_pkg::TYPE_ARP;
  endproperty
  property p_first;
    s_arp |=> key_data[4] == $past(frm_first_lookup);
  endproperty
  property p_smac;
    s_arp |=> key_data[93:46] == $past(src_mac_field);
  endproperty
  property p_len;
    s_arp |=> key_data[96] ==
      ($past(arp_hw_len) == 8'h06 && $past(arp_proto_len) == 8'h04);
  endproperty
  property p_op;
    s_arp ##0 (arp_op inside {[16'h1:16'h4]}) |=>
      !key_data[99] && key_data[101:100] == 2'($past(arp_op) - 16'h1);
  endproperty
  property p_unk;
    s_arp ##0 !(arp_op inside {[16'h1:16'h4]}) |=> key_data[99];
  endproperty
  property p_ipeq;
    s_arp |=> key_data[166] == ($past(arp_sender_ip) == $past(arp_target_ip));
  endproperty
  property p_ip_type;
    s_ip |=> key_valid && key_data[3:0] == akb_pkg::TYPE_IP4_L4 &&
      key_data[46];
  endproperty
  property p_tcp;
    s_ip |=> key_data[124] == ($past(ip_proto) == akb_pkg::PROTO_TCP);
  endproperty
  property p_l4_dc;
    s_ip ##0 (ip_frag_offset != 13'h0 || ip_hdr_len > 4'h5) |=>
      key_mask[184:125] == '0;
  endproperty
  property p_hold;
    key_valid && !key_ready |=> key_valid && $stable(key_data);
  endproperty
  property p_refuse;
    key_valid && !key_ready |-> !frm_ready;
  endproperty
  a_arp_type: assert property (p_arp_type)
    else $error("arp key type wrong");
  a_first: assert property (p_first) else $error("first bit wrong");
  a_smac: assert property (p_smac) else $error("source mac wrong");
  a_len: assert property (p_len) else $error("length flag wrong");
  a_op: assert property (p_op) else $error("operation field wrong");
  a_unk: assert property (p_unk) else $error("unknown op flag low");
  a_ipeq: assert property (p_ipeq) else $error("arp ip equal wrong");
  a_ip_type: assert property (p_ip_type)
    else $error("ip key type wrong");
  a_tcp: assert property (p_tcp) else $error("tcp flag wrong");
  a_l4_dc: assert property (p_l4_dc) else $error("l4 not masked");
  a_hold: assert property (p_hold) else $error("key not held");
  a_refuse: assert property (p_refuse) else $error("frame taken on stall");
endmodule
bind akb_key_builder akb_key_builder_checker i_akb_key_builder_checker (.*);
`default_nettype wire

// [akb_tcam_model.sv]
`default_nettype none
module akb_tcam_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic key_valid,
  output logic key_ready,
  input wire logic [akb_pkg::KEY_W-1:0] key_data,
  input wire logic [akb_pkg::KEY_W-1:0] key_mask,
  output logic [akb_pkg::KEY_W-1:0] got_d,
  output logic [akb_pkg::KEY_W-1:0] got_m,
  output var int got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // a busy match array is modelled by holding ready low
  assign key_ready = !stall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_cnt <= 0;
      got_d <= '0;
      got_m <= '0;
    end else if (key_valid && key_ready) begin
      got_cnt <= got_cnt + 1;
      got_d <= key_data;
      got_m <= key_mask;
    end
  end
endmodule
`default_nettype wire

// [akb_key_builder_tb.sv]
`default_nettype none
module akb_key_builder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic [11:0] paddr = '0, cls_vid = '0;
  logic [31:0] pwdata = '0, prdata, rd, tcp_seq = '0;
  logic pready, pslverr, frm_ready, key_valid, key_ready, er;
  logic frm_valid = 0, frm_first_lookup = 0, frm_is_arp = 0, frm_is_ip4 = 0;
  logic frm_is_ptp = 0, frm_is_ip6 = 0, ip_more_frags = 0;
  logic [47:0] src_mac_field = '0, arp_sender_hw = '0, arp_target_hw = '0;
  logic [15:0] arp_hw_space = '0, arp_proto_space = '0, arp_op = '0;
  logic [15:0] src_port_field = '0, dest_port_field = '0;
  logic [7:0] arp_hw_len = '0, arp_proto_len = '0, ip_ttl = '0, ip_proto = '0;
  logic [7:0] service_type_field = '0, ptp_flag_field = '0;
  logic [7:0] ptp_domain_field = '0;
  logic [31:0] arp_sender_ip = '0, arp_target_ip = '0;
  logic [12:0] ip_frag_offset = '0;
  logic [3:0] ip_hdr_len = '0, ptp_msg_type = '0, ptp_version_field = '0;
  logic [127:0] ip_src = '0, ip_dst = '0;
  logic [5:0] tcp_flags = '0, cls_dscp = '0;
  logic [184:0] key_data, key_mask, got_d, got_m;
  int got_cnt, err_total = 0, checked = 0;
  always #5 pclk = ~pclk;
  akb_key_builder i_akb_key_builder (.*);
  akb_tcam_model i_akb_tcam_model (.pclk, .presetn, .stall, .key_valid,
    .key_ready, .key_data, .key_mask, .got_d, .got_m, .got_cnt);
  task automatic close_out;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang;
    err_total++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    close_out();
  endtask
  function automatic logic [63:0] fld(input logic [184:0] k, input int p,
                                      input int w);
    return 64'(k >> p) & ((64'h1 << w) - 64'h1);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send;
    int n;
    int c;
    c = got_cnt;
    @(posedge pclk);
    frm_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (frm_ready !== 1'b1 && n < 50);
    frm_valid <= 1'b0;
    while (got_cnt == c && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) hang();
  endtask
  // ranges: 1 misses sport 0x50, 4 checks dscp, 5 never hits
  task automatic t_regs;
    apb(1'b0, akb_pkg::ADDR_CTRL, 32'h0);
    chk(64'(rd), 64'(akb_pkg::CTRL_RST));
    apb(1'b0, 12'h100, 32'h0);
    chk({63'h0, er}, 64'h1);
    apb(1'b1, akb_pkg::ADDR_RBASE + 12'h4, 32'h0060_0051);
    apb(1'b0, akb_pkg::ADDR_RBASE + 12'h4, 32'h0);
    chk(64'(rd), 64'h0060_0051);
    apb(1'b1, akb_pkg::ADDR_RBASE + 12'h10, 32'h0020_0010);
    apb(1'b1, akb_pkg::ADDR_RTYPE, 32'h0002_c600);
  endtask
  task automatic t_arp;
    logic [47:0] mac;
    for (int k = 1; k <= 5; k++) begin
      mac = 48'h0a1b_2c3d_4e50 + 48'(k);
      frm_is_arp <= 1'b1;
      frm_first_lookup <= k[0];
      src_mac_field <= mac;
      arp_sender_hw <= (k == 2) ? 48'h0 : mac;
      arp_target_hw <= (k == 3) ? mac : 48'h0;
      arp_hw_space <= k[0] ? akb_pkg::HTYPE_ETH : 16'h0006;
      arp_proto_space <= (k == 5) ? 16'h86dd : akb_pkg::PTYPE_IP;
      arp_hw_len <= akb_pkg::HLEN_ETH;
      arp_proto_len <= (k == 2) ? 8'h05 : akb_pkg::PLEN_IP;
      arp_op <= 16'(k);
      arp_target_ip <= 32'hc0a8_0001;
      arp_sender_ip <= (k == 4) ? 32'hc0a8_0001 : 32'hc0a8_0063;
      send();
      chk(fld(got_d, 0, 5), {59'h0, k[0], 4'h3});
      chk(fld(got_m, 0, 8), 64'h1f);
      chk(fld(got_d, 46, 48), 64'(mac));
      chk(fld(got_d, 94, 3), {61'h0, k != 2, k != 5, k[0]});
      chk(fld(got_d, 97, 3), {61'h0, k == 5, k != 2, k == 3});
      chk(fld(got_d, 100, 2), 64'((k - 1) % 4));
      chk(fld(got_d, 102, 64), {arp_sender_ip, 32'hc0a8_0001});
      chk(fld(got_d, 166, 1), 64'(k == 4));
    end
    frm_is_arp <= 1'b0;
  endtask
  task automatic t_tcp;
    frm_is_ip4 <= 1'b1;
    frm_first_lookup <= 1'b0;
    ip_proto <= akb_pkg::PROTO_TCP;
    ip_more_frags <= 1'b1;
    ip_hdr_len <= akb_pkg::IHL_PLAIN;
    service_type_field <= 8'ha5;
    ip_src <= 128'hc0a8_0102;
    ip_dst <= 128'hc0a8_0102;
    src_port_field <= 16'h0050;
    dest_port_field <= 16'h0050;
    tcp_flags <= 6'h2a;
    cls_dscp <= 6'h15;
    send();
    chk(fld(got_d, 0, 5), 64'h4);
    chk(fld(got_d, 46, 13), {51'h0, 8'ha5, 5'b00011});
    chk(fld(got_d, 59, 64), {2{32'hc0a8_0102}});
    chk(fld(got_d, 123, 2), 64'h3);
    chk(fld(got_d, 125, 32), 64'h0050_0050);
    chk(fld(got_d, 157, 16), {48'h0, 6'h2a, 2'b11, 8'hdd});
    chk(fld(got_m, 125, 48), 64'hffff_ffff_ffff);
  endtask
  task automatic t_ptp;
    ip_proto <= akb_pkg::PROTO_UDP;
    frm_is_ptp <= 1'b1;
    ip_more_frags <= 1'b0;
    ip_ttl <= 8'h40;
    ip_dst <= 128'hc0a8_0103;
    src_port_field <= 16'h013f;
    ptp_msg_type <= 4'hb;
    ptp_flag_field <= 8'h86;
    ptp_domain_field <= 8'h2c;
    ptp_version_field <= 4'h2;
    send();
    chk(fld(got_d, 46, 5), 64'h11);
    chk(fld(got_d, 123, 2), 64'h0);
    chk(fld(got_d, 165, 20), {44'h0, 4'h2, 8'h2c, 3'b111, 4'hb, 1'b0});
    frm_is_ptp <= 1'b0;
  endtask
  task automatic t_l4_dc;
    ip_proto <= akb_pkg::PROTO_TCP;
    for (int k = 0; k < 2; k++) begin
      ip_frag_offset <= (k == 0) ? 13'h5 : 13'h0;
      ip_hdr_len <= (k == 0) ? akb_pkg::IHL_PLAIN : 4'h6;
      send();
      chk(fld(got_d, 47, 3), (k == 0) ? 64'h3 : 64'h4);
      chk(fld(got_m, 125, 60), 64'h0);
    end
    ip_hdr_len <= akb_pkg::IHL_PLAIN;
  endtask
  // low halves match, so only a full-width compare clears the equal flag
  task automatic t_v6;
    apb(1'b1, akb_pkg::ADDR_CTRL, 32'h0);
    frm_is_ip4 <= 1'b0;
    frm_is_ip6 <= 1'b1;
    ip_src <= 128'h2001_0db8_0000_0000_1111_2222_3333_4444;
    ip_dst <= 128'h2001_0db9_0000_0000_1111_2222_3333_4444;
    send();
    chk(fld(got_d, 46, 1), 64'h0);
    chk(fld(got_d, 59, 64), 64'h3333_4444_1111_2222);
    chk(fld(got_d, 123, 1), 64'h0);
    frm_is_ip6 <= 1'b0;
    frm_is_ip4 <= 1'b1;
  endtask
  task automatic t_stall;
    int c;
    c = got_cnt;
    stall <= 1'b1;
    @(posedge pclk);
    frm_valid <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({62'h0, key_valid, frm_ready}, 64'h2);
    stall <= 1'b0;
    @(posedge pclk);
    frm_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(64'(got_cnt - c), 64'h2);
    // twelve keys built over the whole run, none skipped
    apb(1'b0, akb_pkg::ADDR_STAT, 32'h0);
    chk(64'(rd), 64'h0000_000c);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_arp();
    t_tcp();
    t_ptp();
    t_l4_dc();
    t_v6();
    t_stall();
    close_out();
  end
endmodule
`default_nettype wire
